// *** shared/sbsram_pkg.sv ***
`default_nettype none
package sbsram_pkg;
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 16;
	localparam int WORD_W  = 18;
	localparam int BYTE_W  = 8;
	localparam int BURST_W = 2;
	localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
endpackage
`default_nettype wire

// *** rtl/sbsram_burst_ctr.sv ***
`default_nettype none
module sbsram_burst_ctr
	import sbsram_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic               load,
	input  wire logic               step,
	input  wire logic               order_interleaved,
	input  wire logic [BURST_W-1:0] start_bits,
	output logic      [BURST_W-1:0] burst_bits
);
	logic [BURST_W-1:0] start;
	logic [BURST_W-1:0] count;

	// the count stays two bits wide so it never carries upward
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			start <= BURST_ZERO;
			count <= BURST_ZERO;
		end else if (load) begin
			start <= start_bits;
			count <= BURST_ZERO;
		end else if (step) begin
			count <= count + BURST_ONE;
		end
	end

	// order select is combinational: the strap is never clocked and may change at any time
	always_comb begin
		if (order_interleaved) begin
			burst_bits = start ^ count;
		end else begin
			burst_bits = start + count;
		end
	end
endmodule
`default_nettype wire

// *** rtl/sbsram_core.sv ***
`default_nettype none
module sbsram_core
	import sbsram_pkg::*;
#(
	parameter int DEPTH = 65536
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] word_addr_pins,
	input  wire logic              primary_select_n,
	input  wire logic              second_select_n,
	input  wire logic              third_select_hi,
	input  wire logic              proc_addr_strobe_n,
	input  wire logic              ctrl_addr_strobe_n,
	input  wire logic              burst_step_n,
	input  wire logic              low_byte_wr_n,
	input  wire logic              high_byte_wr_n,
	input  wire logic              byte_write_gate_n,
	input  wire logic              full_word_write_n,
	input  wire logic              output_enable_n,
	input  wire logic              burst_order_hi,
	input  wire logic              sleep_request,
	input  wire logic [DATA_W-1:0] shared_data_pins_in,
	input  wire logic              low_parity_pin_in,
	input  wire logic              high_parity_pin_in,
	output logic      [DATA_W-1:0] shared_data_pins_out,
	output logic                   low_parity_pin_out,
	output logic                   high_parity_pin_out,
	output logic                   data_pins_oe
);
	// --------------------------------------------------------
	// input capture
	// --------------------------------------------------------
	logic [ADDR_W-1:0] addr_reg;
	logic              selected;
	logic              in_burst;
	logic              read_armed;
	logic              wr_low;
	logic              wr_high;
	logic [WORD_W-1:0] wr_data;
	logic              wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	logic [WORD_W-1:0] rd_word;
	logic              rd_valid;
	logic [BURST_W-1:0] burst_bits;
	logic [ADDR_W-1:0] cur_addr;
	logic [WORD_W-1:0] mem [DEPTH];

	logic proc_start;
	logic ctrl_start;
	logic any_start;
	logic chip_on;
	logic byte_wr_low;
	logic byte_wr_high;
	logic step_now;

	assign chip_on    = !primary_select_n && !second_select_n && third_select_hi;
	assign proc_start = !proc_addr_strobe_n && !primary_select_n;
	assign ctrl_start = !ctrl_addr_strobe_n && proc_addr_strobe_n;
	assign any_start  = proc_start || ctrl_start;
	// full-word write overrides the gate; byte enables need the gate low
	assign byte_wr_low  = !full_word_write_n || (!byte_write_gate_n && !low_byte_wr_n);
	assign byte_wr_high = !full_word_write_n || (!byte_write_gate_n && !high_byte_wr_n);
	assign step_now     = in_burst && !any_start && !burst_step_n;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_reg <= '0;
			selected <= 1'b0;
			in_burst <= 1'b0;
		end else if (any_start) begin
			addr_reg <= word_addr_pins;
			selected <= chip_on;
			in_burst <= chip_on;
		end
	end

	sbsram_burst_ctr u_ctr (
		.clock             (clock),
		.sys_rst           (sys_rst),
		.load              (any_start),
		.step              (step_now),
		.order_interleaved (burst_order_hi),
		.start_bits        (word_addr_pins[BURST_W-1:0]),
		.burst_bits        (burst_bits)
	);

	assign cur_addr = {addr_reg[ADDR_W-1:BURST_W], burst_bits};

	// --------------------------------------------------------
	// write path: capture, then update the array next edge
	// --------------------------------------------------------
	// a processor strobe never writes and reads only when chip_on is set; writes come on controller
	// strobes or burst continuation cycles
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_pend <= 1'b0;
			wr_low  <= 1'b0;
			wr_high <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_pend <= !proc_start && (byte_wr_low || byte_wr_high)
			           && (ctrl_start ? chip_on : selected);
			wr_low  <= byte_wr_low;
			wr_high <= byte_wr_high;
			wr_addr <= any_start ? word_addr_pins : cur_addr;
			wr_data <= {high_parity_pin_in, low_parity_pin_in, shared_data_pins_in};
		end
	end

	// self-timed array update from captured values only
	always_ff @(posedge clock) begin
		if (wr_pend && wr_low) begin
			mem[wr_addr][BYTE_W-1:0] <= wr_data[BYTE_W-1:0];
			mem[wr_addr][DATA_W]     <= wr_data[DATA_W];
		end
		if (wr_pend && wr_high) begin
			mem[wr_addr][DATA_W-1:BYTE_W] <= wr_data[DATA_W-1:BYTE_W];
			mem[wr_addr][WORD_W-1]        <= wr_data[WORD_W-1];
		end
	end

	// --------------------------------------------------------
	// read path: word 1 after two edges, then one per edge
	// --------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			read_armed <= 1'b0;
		end else begin
			read_armed <= any_start ? (chip_on && (proc_start || !(byte_wr_low || byte_wr_high)))
			              : (read_armed && selected && !(byte_wr_low || byte_wr_high));
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_word  <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_word  <= mem[cur_addr];
			rd_valid <= read_armed && !sleep_request;
		end
	end

	// --------------------------------------------------------
	// pin drive
	// --------------------------------------------------------
	// output enable and sleep are sampled each edge here because every
	// output is registered; true pad timing lies outside this model
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shared_data_pins_out <= '0;
			low_parity_pin_out   <= 1'b0;
			high_parity_pin_out  <= 1'b0;
			data_pins_oe         <= 1'b0;
		end else begin
			shared_data_pins_out <= rd_word[DATA_W-1:0];
			low_parity_pin_out   <= rd_word[DATA_W];
			high_parity_pin_out  <= rd_word[WORD_W-1];
			data_pins_oe <= rd_valid && !output_enable_n && !sleep_request
			                && !(!byte_write_gate_n && (!low_byte_wr_n || !high_byte_wr_n));
		end
	end

	// --------------------------------------------------------
	// checks
	// --------------------------------------------------------
	AST_ADDR_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		!any_start |=> $stable(addr_reg))
		else $error("address changed without a strobe");
	AST_ADDR_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
		any_start |=> addr_reg == $past(word_addr_pins))
		else $error("address not captured on strobe");
	AST_PROC_GATE: assert property (@(posedge clock) disable iff (sys_rst)
		(!proc_addr_strobe_n && primary_select_n && ctrl_addr_strobe_n) |=> $stable(addr_reg))
		else $error("processor strobe taken while unselected");
	AST_PROC_READ: assert property (@(posedge clock) disable iff (sys_rst)
		proc_start |=> !wr_pend)
		else $error("processor strobe started a write");
	// the order strap may change at any time and remaps cur_addr without a
	// clock, so the wait check watches the registered address and count
	AST_WAIT: assert property (@(posedge clock) disable iff (sys_rst)
		(!any_start && burst_step_n) |=> $stable({addr_reg, u_ctr.count}))
		else $error("burst address moved on a wait cycle");
	AST_STEP: assert property (@(posedge clock) disable iff (sys_rst)
		(in_burst && !any_start && !burst_step_n)
		|=> u_ctr.count == $past(u_ctr.count) + BURST_ONE)
		else $error("burst counter did not step on advance");
	AST_FIRST_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
		any_start |=> burst_bits == $past(word_addr_pins[BURST_W-1:0]))
		else $error("first burst address not the external one");
	AST_SELECT: assert property (@(posedge clock) disable iff (sys_rst)
		(ctrl_start && chip_on) |=> selected)
		else $error("controller strobe did not select");
	AST_DESELECT: assert property (@(posedge clock) disable iff (sys_rst)
		(ctrl_start && !chip_on) |=> !selected)
		else $error("controller strobe did not deselect");
	AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
		(ctrl_start && chip_on && !full_word_write_n) |=> wr_pend)
		else $error("controller write not started");
	AST_CTRL_READ: assert property (@(posedge clock) disable iff (sys_rst)
		(ctrl_start && chip_on && full_word_write_n && byte_write_gate_n)
		|=> !wr_pend && read_armed)
		else $error("controller read not started");
	AST_WR_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
		any_start |=> wr_addr == $past(word_addr_pins))
		else $error("write address not captured");
	AST_WR_DATA: assert property (@(posedge clock) disable iff (sys_rst)
		!any_start || any_start |=> wr_data == $past({high_parity_pin_in,
		low_parity_pin_in, shared_data_pins_in}))
		else $error("write data not captured");
	AST_LOW_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
		(full_word_write_n && !byte_write_gate_n && !low_byte_wr_n && high_byte_wr_n)
		|=> wr_low && !wr_high)
		else $error("low byte write touched the high byte");
	AST_HIZ_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
		(!byte_write_gate_n && !high_byte_wr_n) |=> !data_pins_oe)
		else $error("data pins driven during high byte write");
	AST_SLEEP: assert property (@(posedge clock) disable iff (sys_rst)
		sleep_request |=> !data_pins_oe)
		else $error("pins driven while asleep");
	AST_UPPER: assert property (@(posedge clock) disable iff (sys_rst)
		!any_start |=> cur_addr[ADDR_W-1:BURST_W] == $past(cur_addr[ADDR_W-1:BURST_W]))
		else $error("burst carried into upper address");
	AST_GATE_OFF: assert property (@(posedge clock) disable iff (sys_rst)
		(byte_write_gate_n && full_word_write_n) |=> !wr_pend)
		else $error("byte enables wrote with gate high");
	AST_FULL_WORD: assert property (@(posedge clock) disable iff (sys_rst)
		!full_word_write_n |=> wr_low && wr_high)
		else $error("full-word write missed a byte");
	AST_HIZ: assert property (@(posedge clock) disable iff (sys_rst)
		(!byte_write_gate_n && !low_byte_wr_n) |=> !data_pins_oe)
		else $error("data pins driven during byte write");
	AST_OE: assert property (@(posedge clock) disable iff (sys_rst)
		output_enable_n |=> !data_pins_oe)
		else $error("pins driven with output enable high");
	AST_FIRST_WORD: assert property (@(posedge clock) disable iff (sys_rst)
		(proc_start && chip_on && !output_enable_n) ##1 (!output_enable_n && !sleep_request
		&& byte_write_gate_n && !any_start)[*2] |=> data_pins_oe)
		else $error("first burst word not out after two cycles");
endmodule
`default_nettype wire

// *** bench/sbsram_host_bfm.sv ***
`default_nettype none
module sbsram_host_bfm (
	input  wire logic        clock,
	input  wire logic        drive_en,
	input  wire logic [17:0] drive_word,
	input  wire logic        dev_oe,
	input  wire logic [17:0] dev_word,
	output logic      [17:0] pin_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [17:0] last = 18'h0_0000;
	// pins have no pull: released lines toggle so stale data never passes
	always_comb begin
		if (dev_oe)
			pin_word = dev_word;
		else if (drive_en)
			pin_word = drive_word;
		else
			pin_word = ~last;
	end
	always_ff @(posedge clock) begin
		last <= pin_word;
	end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`default_nettype none
module tb_top;
	import sbsram_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, sys_rst = 1, sel3 = 1, proc_addr_strobe_n_n = 1, ctrl_addr_strobe_n_n = 1, step_n = 1;
	logic wl_n = 1, wh_n = 1, gate_n = 1, gw_n = 1, oe_n = 0, order = 0, sleep = 0;
	logic [15:0] addr = 16'h0000;
	logic [17:0] drv_word = 18'h0_0000, pin_word;
	logic [15:0] dout;
	logic lpo, hpo, oe, drv = 0;
	logic [17:0] mem [int];
	int mismatches = 0, cmp_count = 0, cycles = 0;

	sbsram_core dut_u (.clock(clock), .sys_rst(sys_rst), .word_addr_pins(addr),
		.primary_select_n(1'b0), .second_select_n(1'b0), .third_select_hi(sel3),
		.proc_addr_strobe_n(proc_addr_strobe_n_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n_n), .burst_step_n(step_n),
		.low_byte_wr_n(wl_n), .high_byte_wr_n(wh_n), .byte_write_gate_n(gate_n),
		.full_word_write_n(gw_n), .output_enable_n(oe_n), .burst_order_hi(order),
		.sleep_request(sleep), .shared_data_pins_in(pin_word[15:0]),
		.low_parity_pin_in(pin_word[16]), .high_parity_pin_in(pin_word[17]),
		.shared_data_pins_out(dout), .low_parity_pin_out(lpo),
		.high_parity_pin_out(hpo), .data_pins_oe(oe));
	sbsram_host_bfm host_u (.clock(clock), .drive_en(drv), .drive_word(drv_word),
		.dev_oe(oe), .dev_word({hpo, lpo, dout}), .pin_word(pin_word));

	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// ctl = {full word, gate, high enable, low enable}, all active low
	// output enable goes high one cycle ahead: a finished read keeps the
	// pins driven, and the registered enable needs a cycle to let go
	task automatic write(input logic [15:0] a, input logic [17:0] d, input logic [3:0] ctl);
		@(posedge clock);
		oe_n <= 1;
		@(posedge clock);
		ctrl_addr_strobe_n_n <= 0; addr <= a; {gw_n, gate_n, wh_n, wl_n} <= ctl; drv <= 1; drv_word <= d;
		if (!ctl[3])
			mem[a] = d;
		else if (!ctl[2]) begin
			if (!ctl[0]) {mem[a][16], mem[a][7:0]} = {d[16], d[7:0]};
			if (!ctl[1]) {mem[a][17], mem[a][15:8]} = {d[17], d[15:8]};
		end
		@(posedge clock);
		ctrl_addr_strobe_n_n <= 1; {gw_n, gate_n, wh_n, wl_n} <= 4'hf; drv <= 0; oe_n <= 0;
		@(posedge clock);
	endtask
	task automatic burst_read(input logic [15:0] a, input logic ord);
		logic [1:0] k;
		@(posedge clock);
		order <= ord; proc_addr_strobe_n_n <= 0; addr <= a; step_n <= 0;
		@(posedge clock);
		proc_addr_strobe_n_n <= 1;
		// an earlier read may still drive, so latency is judged by the data
		repeat (2) begin
			@(posedge clock);
			#1;
		end
		check({17'h0_0000, oe}, 18'h0_0001);
		for (int i = 0; i < 4; i++) begin
			k = ord ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
			check(pin_word, mem[{a[15:2], k}]);
			@(posedge clock);
			if (i < 3) #1;
		end
		step_n <= 1;
	endtask
	// ctl = {third select, output enable n, sleep}: pins must stay released
	task automatic quiet(input logic [2:0] ctl);
		@(posedge clock);
		ctrl_addr_strobe_n_n <= 0; {sel3, oe_n, sleep} <= ctl; step_n <= 0;
		@(posedge clock);
		ctrl_addr_strobe_n_n <= 1;
		// words already in the read pipeline drain first
		repeat (2) @(posedge clock);
		repeat (5) begin
			@(posedge clock);
			#1;
			check({17'h0_0000, oe}, 18'h0_0000);
		end
		@(posedge clock);
		{sel3, oe_n, sleep} <= 3'b100; step_n <= 1;
	endtask

	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 0;
		for (int i = 0; i < 4; i++)
			write(16'h1230 + 16'(i), 18'h3_a5c0 ^ 18'(i * 18'h0_1357), 4'b0111);
		burst_read(16'h1231, 1'b0);
		burst_read(16'h1233, 1'b0);
		burst_read(16'h1232, 1'b1);
		burst_read(16'h1231, 1'b1);
		write(16'h1230, 18'h1_00ff, 4'b1010);
		write(16'h1231, 18'h2_ff00, 4'b1001);
		write(16'h1232, 18'h3_ffff, 4'b1100);
		write(16'h1233, 18'h0_0000, 4'b0011);
		burst_read(16'h1230, 1'b0);
		quiet(3'b110);
		quiet(3'b101);
		quiet(3'b000);
		give_verdict();
	end
endmodule
`default_nettype wire
